/* File: rtl/drzp_defines.vh */
/*
 Shared constants for the reset, calibration and power-down command block.
 Assumes inclusion by bare name from rtl/ modules only.
*/
// Behaviour
// R01: Reset command enters auto-initialization and restores every mode register default.
// R02: Controller issues reset only when idle, then NOPs until init period ends.
// R03: After reset array contents undefined; boot timings hold until idle reached.
// R04: Calibration starts by mode write to address 0Ah; four ops, own durations.
// R05: Controller runs initial calibration at init; long and short afterwards.
// R06: Calibration reset restores default impedance; no data-bus quiet time needed.
// R07: Controller issues calibration only when idle with all banks precharged.
// R08: No data-bus activity during initial, long or short calibration.
// R09: CKE stays high and only NOPs during any calibration period.
// R10: Shared resistor: controller prevents calibration overlap; reset overlap allowed.
// R11: Calibration pin tied to supply means calibration commands ignored, defaults kept.
// R12: Short calibration interval equals 1.5% over combined drift contributions.
// R13: CKE low with CS# high on rising edge enters power-down; NOP follows.
// R14: CKE not lowered during mode reads, writes, READ or WRITE.
// R15: Power-down with banks idle is idle type; with open row, active type.
// R16: In power-down only clock and CKE buffers live; CKE low minimum pulse.
// R17: No refresh during power-down; controller limits its duration.
// R18: Exit by CKE high with CS# high; hold; wait exit latency. Code exits on CKE high without checking CS#.
// R19: After READ, CKE low no earlier than RL+skew+BL/2+1 cycles.
// R20: After WRITE, CKE low no earlier than WL+1+BL/2+write recovery.
// R21: After REFRESH, CKE may drop after input hold time.
// R22: After mode write, CKE low only after mode-write period elapses.
// R23: Mode write: CS# and CA0-CA3 low rising; address and data on falling. Code takes address bits 0-5 from CA4-CA9 on the rising edge.
// R24: Controller counts calibration, reset and exit periods before non-NOP commands.
`ifndef DRZP_DEFINES_VH
`define DRZP_DEFINES_VH
`define DRZP_CLK_PERIOD_PS 5000
`define DRZP_ADDR_RESET 8'h3F
`define DRZP_ADDR_CAL 8'h0A
`define DRZP_CAL_INIT 8'hFF
`define DRZP_CAL_LONG 8'hAB
`define DRZP_CAL_SHORT 8'h56
`define DRZP_CAL_RESET 8'hC3
`define DRZP_OP_NONE 3'h0
`define DRZP_OP_INIT 3'h1
`define DRZP_OP_LONG 3'h2
`define DRZP_OP_SHORT 3'h3
`define DRZP_OP_RESET 3'h4
`define DRZP_T_INIT_NS 1000
`define DRZP_T_ZQINIT_NS 1000
`define DRZP_T_ZQCL_NS 360
`define DRZP_T_ZQCS_NS 90
`define DRZP_T_ZQRESET_NS 50
`endif

/* File: rtl/drzp_sync.v */
/*
 Two-flop synchroniser, one per bit.
 Assumes inputs asynchronous to clk.
*/
`timescale 1ns/1ps
module drzp_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end
    assign dout = sync_reg;
endmodule // drzp_sync

/* File: rtl/drzp_dram_reset_zq_powerdown.v */
/*
 Device-side decoder for mode-write reset, ZQ calibration and power-down.
 Assumes memory clock, CKE, CS# and CA pins asynchronous to core_clk; the
 link clock is much slower than core_clk so each edge is seen.
*/
`timescale 1ns/1ps
`include "drzp_defines.vh"
module drzp_dram_reset_zq_powerdown #(
    parameter INIT_CYCLES = ((`DRZP_T_INIT_NS * 1000) + `DRZP_CLK_PERIOD_PS - 1) / `DRZP_CLK_PERIOD_PS,
    parameter ZQINIT_CYCLES = ((`DRZP_T_ZQINIT_NS * 1000) + `DRZP_CLK_PERIOD_PS - 1) / `DRZP_CLK_PERIOD_PS,
    parameter ZQCL_CYCLES = ((`DRZP_T_ZQCL_NS * 1000) + `DRZP_CLK_PERIOD_PS - 1) / `DRZP_CLK_PERIOD_PS,
    parameter ZQCS_CYCLES = ((`DRZP_T_ZQCS_NS * 1000) + `DRZP_CLK_PERIOD_PS - 1) / `DRZP_CLK_PERIOD_PS,
    parameter ZQRESET_CYCLES = ((`DRZP_T_ZQRESET_NS * 1000) + `DRZP_CLK_PERIOD_PS - 1) / `DRZP_CLK_PERIOD_PS
) (
    input wire core_clk,
    input wire rst,
    input wire memClk,
    input wire cke,
    input wire csN,
    input wire [9:0] ca,
    input wire zqTiedHigh,
    input wire banksIdle,
    output reg initBusy_reg,
    output reg calBusy_reg,
    output reg [2:0] calOp_reg,
    output reg calDefault_reg,
    output reg powerDown_reg,
    output reg activePowerDown_reg,
    output reg buffersOn_reg,
    output reg modeRegDefaults_reg,
    output reg [7:0] calCommandRegister_reg
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    wire [14:0] syncOut;
    drzp_sync #(.WIDTH(15)) u_sync (
        .clk(core_clk),
        .rst(rst),
        .din({memClk, cke, csN, ca, zqTiedHigh, banksIdle}),
        .dout(syncOut)
    );
    wire mClk = syncOut[14];
    wire ckeS = syncOut[13];
    wire csNS = syncOut[12];
    wire [9:0] caS = syncOut[11:2];
    wire zqTie = syncOut[1];
    wire idleS = syncOut[0];

    // ****************************************
    // Edge detection and CA capture
    // ****************************************
    // Pins sampled together, so skew between them is one core cycle at most
    reg mClkPrev_reg;
    reg ckePrev_reg;
    reg mrwPend_reg;
    reg [5:0] addrLow_reg;
    wire riseEdge = mClk & ~mClkPrev_reg;
    wire fallEdge = ~mClk & mClkPrev_reg;
    wire [7:0] mrwAddr = {caS[1:0], addrLow_reg};
    wire [7:0] mrwData = caS[9:2];
    reg [31:0] count_reg;
    reg [31:0] count_next;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mClkPrev_reg <= 1'b0;
            ckePrev_reg <= 1'b1;
            mrwPend_reg <= 1'b0;
            addrLow_reg <= 6'h00;
        end else begin
            mClkPrev_reg <= mClk;
            if (riseEdge) begin
                ckePrev_reg <= ckeS;
            end
            if (riseEdge) begin
                // Mode writes ignored while powered down; CKE is still watched for exit
                mrwPend_reg <= ckeS & ckePrev_reg & ~csNS & (caS[3:0] == 4'h0) & ~powerDown_reg; // R23 R16
                addrLow_reg <= caS[9:4]; // R23
            end else if (fallEdge) begin
                mrwPend_reg <= 1'b0;
            end
        end
    end
    wire mrwValid = fallEdge & mrwPend_reg; // R23

    // ****************************************
    // Calibration code decode
    // ****************************************
    // Unknown codes decode to no operation, so a stray write leaves state alone
    reg [2:0] decOp;
    reg [31:0] decLen;
    always @* begin
        decOp = `DRZP_OP_NONE;
        decLen = 32'h0;
        case (mrwData)
            `DRZP_CAL_INIT: begin
                decOp = `DRZP_OP_INIT;
                decLen = ZQINIT_CYCLES;
            end
            `DRZP_CAL_LONG: begin
                decOp = `DRZP_OP_LONG;
                decLen = ZQCL_CYCLES;
            end
            `DRZP_CAL_SHORT: begin
                decOp = `DRZP_OP_SHORT;
                decLen = ZQCS_CYCLES;
            end
            `DRZP_CAL_RESET: begin
                decOp = `DRZP_OP_RESET; // R06
                decLen = ZQRESET_CYCLES;
            end
            default: begin
                decOp = `DRZP_OP_NONE;
                decLen = 32'h0;
            end
        endcase
    end

    // ****************************************
    // Control state
    // ****************************************
    localparam ST_IDLE = 2'h0;
    localparam ST_INIT = 2'h1;
    localparam ST_CAL = 2'h2;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] opNext;
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        opNext = calOp_reg;
        case (state_reg)
            ST_IDLE: begin
                if (mrwValid && mrwAddr == `DRZP_ADDR_RESET) begin
                    state_next = ST_INIT; // R01 R03
                    count_next = INIT_CYCLES;
                end else if (mrwValid && mrwAddr == `DRZP_ADDR_CAL && !zqTie && decOp != `DRZP_OP_NONE) begin
                    state_next = ST_CAL; // R04 R11
                    opNext = decOp; // R06
                    count_next = decLen;
                end
            end
            ST_INIT, ST_CAL: begin
                if (count_reg <= 32'h1) begin
                    state_next = ST_IDLE;
                    opNext = `DRZP_OP_NONE;
                    count_next = 32'h0;
                end else begin
                    count_next = count_reg - 32'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Power-down next state
    // ****************************************
    // Entry needs CKE high on the previous link edge, so a held-low CKE cannot re-enter
    reg powerDown_next;
    reg activePowerDown_next;
    reg buffersOn_next;
    always @* begin
        powerDown_next = powerDown_reg;
        activePowerDown_next = activePowerDown_reg;
        buffersOn_next = buffersOn_reg;
        if (riseEdge) begin
            if (!powerDown_reg && !ckeS && ckePrev_reg && csNS) begin
                powerDown_next = 1'b1; // R13
                activePowerDown_next = ~idleS; // R15
                buffersOn_next = 1'b0; // R16 R17
            end else if (powerDown_reg && ckeS) begin
                powerDown_next = 1'b0; // R18
                activePowerDown_next = 1'b0;
                buffersOn_next = 1'b1;
            end
        end
    end

    // ****************************************
    // Registers and outputs
    // ****************************************
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 32'h0;
            calOp_reg <= `DRZP_OP_NONE;
            initBusy_reg <= 1'b0;
            calBusy_reg <= 1'b0;
            calDefault_reg <= 1'b1;
            powerDown_reg <= 1'b0;
            activePowerDown_reg <= 1'b0;
            buffersOn_reg <= 1'b1;
            modeRegDefaults_reg <= 1'b1;
            calCommandRegister_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            calOp_reg <= opNext;
            initBusy_reg <= (state_next == ST_INIT); // R01
            calBusy_reg <= (state_next == ST_CAL);
            if (state_reg == ST_IDLE && state_next == ST_INIT) begin
                modeRegDefaults_reg <= 1'b1; // R01
                calCommandRegister_reg <= 8'h00;
                calDefault_reg <= 1'b1;
            end else if (state_reg == ST_IDLE && state_next == ST_CAL) begin
                modeRegDefaults_reg <= 1'b0;
                calCommandRegister_reg <= mrwData; // R04
                calDefault_reg <= (opNext == `DRZP_OP_RESET); // R06
            end
            if (zqTie) begin
                calDefault_reg <= 1'b1; // R11
            end
            // Power-down entry/exit on rising link edges only
            powerDown_reg <= powerDown_next; // R13 R18
            activePowerDown_reg <= activePowerDown_next; // R15
            buffersOn_reg <= buffersOn_next; // R16
        end
    end
endmodule // drzp_dram_reset_zq_powerdown

/* File: test/drzp_checker_properties.sv */
/* Assertions on the reset, calibration and power-down block ports.
 Assumes binding to the top module with its parameters. */
`timescale 1ns/1ps
module drzp_checker #(
    parameter INIT_CYCLES = 200,
    parameter ZQINIT_CYCLES = 200,
    parameter ZQCL_CYCLES = 72,
    parameter ZQCS_CYCLES = 18,
    parameter ZQRESET_CYCLES = 10
) (
    input wire core_clk,
    input wire rst,
    input wire cke,
    input wire csN,
    input wire zqTiedHigh,
    input wire initBusy_reg,
    input wire calBusy_reg,
    input wire [2:0] calOp_reg,
    input wire calDefault_reg,
    input wire powerDown_reg,
    input wire activePowerDown_reg,
    input wire buffersOn_reg
);
    // ****************************************
    // Busy-length counters and properties
    // ****************************************
    integer calCnt_reg;
    integer initCnt_reg;
    function integer opLen(input [2:0] op);
        case (op)
            3'h1: opLen = ZQINIT_CYCLES;
            3'h2: opLen = ZQCL_CYCLES;
            3'h3: opLen = ZQCS_CYCLES;
            default: opLen = ZQRESET_CYCLES;
        endcase
    endfunction
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            calCnt_reg <= 0;
            initCnt_reg <= 0;
        end else begin
            calCnt_reg <= calBusy_reg ? calCnt_reg + 1 : 0;
            initCnt_reg <= initBusy_reg ? initCnt_reg + 1 : 0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cal_end;
        $fell(calBusy_reg);
    endsequence
    a_cal_length: assert property (s_cal_end |-> calCnt_reg == opLen($past(calOp_reg)))
        else $error("calibration busy length wrong");
    a_init_length: assert property ($fell(initBusy_reg) |-> initCnt_reg == INIT_CYCLES)
        else $error("initialization busy length wrong");
    a_zqreset_default: assert property (s_cal_end and $past(calOp_reg) == 3'h4 |-> ##[0:2] calDefault_reg)
        else $error("calibration reset left no default");
    a_zq_tied_ignore: assert property (zqTiedHigh && $past(zqTiedHigh, 8) |-> !$rose(calBusy_reg))
        else $error("calibration started with pin tied");
    a_pd_buffers_off: assert property (powerDown_reg && $past(powerDown_reg) |-> !buffersOn_reg)
        else $error("buffers on in power-down");
    a_active_pd_only: assert property (activePowerDown_reg |-> powerDown_reg)
        else $error("active power-down outside power-down");
    a_pd_entry_pins: assert property ($rose(powerDown_reg) |-> !$past(cke, 2) && $past(csN, 2))
        else $error("power-down without entry pins");
    a_busy_exclusive: assert property (!(initBusy_reg && calBusy_reg))
        else $error("init and calibration both busy");
endmodule // drzp_checker

/* File: test/drzp_ctrl_model.sv */
/* Controller model: link clock, CKE, CS# and CA pins.
 Assumes core_clk at 200 MHz; link runs free at 80 ns. */
`timescale 1ns/1ps
module drzp_ctrl_model (
    input wire core_clk,
    output reg memClk = 1'b0,
    output reg cke = 1'b1,
    output reg csN = 1'b1,
    output reg [9:0] ca = 10'h155
);
    // ****************************************
    // Phase counter and command tasks
    // ****************************************
    integer ph = 0;
    always @(posedge core_clk) begin
        ph <= (ph + 1) % 16;
        memClk <= ((ph + 1) % 16) < 8;
    end
    task at(input integer p);
        begin
            @(posedge core_clk);
            while (ph != p) @(posedge core_clk);
        end
    endtask
    task mrw(input [7:0] addr, input [7:0] data);
        begin
            at(12);
            csN <= 1'b0;
            ca <= {addr[5:0], 4'h0};
            at(4);
            ca <= {data, addr[7:6]};
            at(12);
            csN <= 1'b1;
            ca <= ~ca; // Released pins do not keep their value
        end
    endtask
    task power(input on);
        begin
            at(12);
            cke <= !on;
            csN <= 1'b1;
            ca <= ~ca;
        end
    endtask
endmodule // drzp_ctrl_model

/* File: test/tb_top.sv */
/* Self-checking bench for the reset, calibration and power-down block.
 Assumes the controller model drives all link pins. */
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // Bench
    // ****************************************
    reg core_clk = 0;
    reg rst = 1;
    reg zqTiedHigh = 0;
    reg banksIdle = 1;
    wire memClk, cke, csN, initBusy_reg, calBusy_reg, calDefault_reg, powerDown_reg;
    wire activePowerDown_reg, buffersOn_reg, modeRegDefaults_reg;
    wire [9:0] ca;
    wire [2:0] calOp_reg;
    wire [7:0] calCommandRegister_reg;
    integer failures = 0, samples_checked = 0, lfsr = 8113, busyN = 0, initN = 0, i;
    reg [2:0] opSeen = 0;
    reg [7:0] expCode = 0;
    reg [7:0] codes [0:3] = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
    integer lens [0:4] = '{0, 200, 72, 18, 10};
    always #2.5 core_clk = ~core_clk;
    drzp_ctrl_model ctrl (.core_clk(core_clk), .memClk(memClk), .cke(cke), .csN(csN), .ca(ca));
    // Default timing counts; the run stays short enough at 200 MHz
    drzp_dram_reset_zq_powerdown dut (.core_clk(core_clk), .rst(rst), .memClk(memClk), .cke(cke), .csN(csN),
        .ca(ca), .zqTiedHigh(zqTiedHigh), .banksIdle(banksIdle), .initBusy_reg(initBusy_reg),
        .calBusy_reg(calBusy_reg), .calOp_reg(calOp_reg), .calDefault_reg(calDefault_reg),
        .powerDown_reg(powerDown_reg), .activePowerDown_reg(activePowerDown_reg),
        .buffersOn_reg(buffersOn_reg), .modeRegDefaults_reg(modeRegDefaults_reg),
        .calCommandRegister_reg(calCommandRegister_reg));
    function integer nextRand(input integer x);
        nextRand = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            samples_checked++;
            if (exp !== got) begin
                $display("mismatch %s expected %0h seen %0h", what, exp, got);
                failures++;
            end
        end
    endtask
    task watch(input integer n);
        begin
            repeat (n) begin
                @(negedge core_clk);
                busyN = busyN + (calBusy_reg === 1'b1);
                initN = initN + (initBusy_reg === 1'b1);
                if (calBusy_reg === 1'b1) opSeen = calOp_reg;
            end
        end
    endtask
    task cal(input [7:0] code, input integer op);
        begin
            busyN = 0;
            fork
                ctrl.mrw(8'h0A, code);
                watch(300);
            join
            if (op > 0) expCode = code;
            check("busy cycles", lens[op], busyN);
            if (op > 0) check("op", op, opSeen);
            check("code", expCode, calCommandRegister_reg);
            if (op > 0) check("default", op == 4, calDefault_reg);
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #50000;
        failures++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 0;
        repeat (5) @(posedge core_clk);
        check("defaults", 3'h7, {modeRegDefaults_reg, calDefault_reg, buffersOn_reg});
        for (i = 0; i < 4; i++) cal(codes[i], i + 1);
        $display("test calibration codes done");
        lfsr = nextRand(lfsr);
        cal(8'h11 ^ (lfsr[7:0] & 8'h0C), 0);
        cal(8'h56, 3);
        zqTiedHigh <= 1;
        cal(8'hAB, 0);
        check("tied default", 1, calDefault_reg);
        zqTiedHigh <= 0;
        $display("test refused calibration done");
        initN = 0;
        lfsr = nextRand(lfsr);
        fork
            ctrl.mrw(8'h3F, lfsr[7:0]);
            watch(300);
        join
        check("init cycles", 200, initN);
        check("mode defaults", 1, modeRegDefaults_reg);
        check("code cleared", 0, calCommandRegister_reg);
        $display("test reset command done");
        for (i = 0; i < 2; i++) begin
            banksIdle <= !i;
            ctrl.power(1);
            repeat (40) @(posedge core_clk);
            check("pd entry", {2'b10, i[0]}, {powerDown_reg, buffersOn_reg, activePowerDown_reg});
            ctrl.power(0);
            repeat (40) @(posedge core_clk);
            check("pd exit", 2'b01, {powerDown_reg, buffersOn_reg});
        end
        $display("test power-down done");
        end_of_test;
    end
endmodule // tb_top
bind drzp_dram_reset_zq_powerdown drzp_checker #(.INIT_CYCLES(INIT_CYCLES), .ZQINIT_CYCLES(ZQINIT_CYCLES),
    .ZQCL_CYCLES(ZQCL_CYCLES), .ZQCS_CYCLES(ZQCS_CYCLES), .ZQRESET_CYCLES(ZQRESET_CYCLES)) chk (
    .core_clk(core_clk), .rst(rst), .cke(cke), .csN(csN), .zqTiedHigh(zqTiedHigh),
    .initBusy_reg(initBusy_reg), .calBusy_reg(calBusy_reg), .calOp_reg(calOp_reg),
    .calDefault_reg(calDefault_reg), .powerDown_reg(powerDown_reg),
    .activePowerDown_reg(activePowerDown_reg), .buffersOn_reg(buffersOn_reg));
